// [logic/tfe_pkg.sv]
// Constants shared by the carrier-load tuner front end.
// Assumes a single 200 MHz clock and an APB register port.
`default_nettype none
package tfe_pkg;
    // Sample path and oscillator widths.
    localparam int TFE_SAMPLE_W = 10;
    localparam int TFE_NCO_W = 32;
    localparam int TFE_LO_W = 9;
    localparam int TFE_MIX_W = TFE_SAMPLE_W + TFE_LO_W + 1;
    localparam int TFE_LUT_IDX_W = 4;
    localparam int TFE_CNT_W = 6;
    localparam int TFE_ADDR_W = 8;
    // Rates: 52 MHz over two to the 32 gives a 0.0121 Hz step.
    localparam int TFE_CLK_MHZ = 200;
    localparam int TFE_MAX_MSPS = 52;
    localparam int TFE_TUNE_REF_MHZ = 52;
    // Register byte offsets.
    localparam logic [7:0] TFE_OFS_HOLD = 8'h00;
    localparam logic [7:0] TFE_OFS_CONFIG = 8'h04;
    localparam logic [7:0] TFE_OFS_CARRIER = 8'h08;
    localparam logic [7:0] TFE_OFS_OFFSET = 8'h0C;
    localparam logic [7:0] TFE_OFS_PHASE = 8'h10;
    localparam logic [7:0] TFE_OFS_STATUS = 8'h14;
    // Configuration and status bit positions.
    localparam int TFE_CFG_OFFBIN = 0;
    localparam int TFE_CFG_COMPLEX = 1;
    localparam int TFE_STS_SHIFTING = 0;
    localparam int TFE_STS_CAPTURE = 1;
    // Reset values.
    localparam logic [31:0] TFE_HOLD_RST = 32'h0000_0000;
    localparam logic [1:0] TFE_CONFIG_RST = 2'h0;
    // Input number formats.
    typedef enum logic {
        TFE_FMT_TWOS = 1'b0,
        TFE_FMT_OFFBIN = 1'b1
    } tfe_fmt_type;
endpackage : tfe_pkg
`default_nettype wire

// [logic/tfe_top.sv]
// Tuner front end: sample capture, carrier oscillator, complex mixer.
// Assumes pins are launched off clk by their sources, and APB on clk.
//
// How it works
// - Samples are captured on the rising edge while the enable is low.
// - Samples are 10 bits, real on the in-phase bus or complex on both.
// - Samples are read as two's complement or offset binary by config.
// - The carrier phase is turned by 0, 90, 180 or 270 degrees by pins.
// - A load pin sampled high copies the holding word to the carrier.
// - The offset word shifts in MSB first, one bit a clock, after sync.
// - Samples are mixed to zero frequency by the complex oscillator.
// - The oscillator steps by about 0.012 Hz at a 52 MHz sample rate.
// - Real or complex streams up to 52 MSPS are processed.
//
// Local design decisions: the address map and register access over APB.
`default_nettype none
module tfe_top #(
    parameter int SAMPLE_W = tfe_pkg::TFE_SAMPLE_W, // Sample width.
    parameter int NCO_W = tfe_pkg::TFE_NCO_W // Accumulator width.
) (
    input wire logic clk, // 200 MHz clock.
    input wire logic sys_rst, // Asynchronous reset, high.
    input wire logic sample_capture_enable_n, // Capture enable, low.
    input wire logic [SAMPLE_W-1:0] inphase_sample_in, // I sample.
    input wire logic [SAMPLE_W-1:0] quad_sample_in, // Q sample.
    input wire logic [1:0] carrier_phase_select, // Quarter turns.
    input wire logic carrier_freq_load, // Load carrier word.
    input wire logic carrier_offset_serial_in, // Serial offset bit.
    input wire logic carrier_offset_sync, // Sync before MSB.
    input wire logic [tfe_pkg::TFE_ADDR_W-1:0] paddr, // APB address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    output logic signed [tfe_pkg::TFE_MIX_W-1:0] mix_i_out, // Mixed I.
    output logic signed [tfe_pkg::TFE_MIX_W-1:0] mix_q_out, // Mixed Q.
    output logic mix_valid // Mixed pair valid.
);
    import tfe_pkg::*;

    localparam int PIN_W = 2 * SAMPLE_W + 6;
    localparam int MIX_W = TFE_MIX_W;
    localparam int LO_W = TFE_LO_W;
    localparam int CNT_W = TFE_CNT_W;
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(NCO_W - 1);
    localparam int QTR_SHIFT = NCO_W - 2;
    // Pin stage resets with the capture enable high, i.e. idle.
    localparam logic [PIN_W-1:0] PIN_RST = {1'b1, {(PIN_W-1){1'b0}}};
    // Oscillator table phase: quadrant bits above the table index.
    localparam int LUT_PH_W = TFE_LUT_IDX_W + 2;
    localparam logic [LUT_PH_W-1:0] LUT_QTR = LUT_PH_W'(1) << TFE_LUT_IDX_W;

    // Pins as they arrive, and as the core uses them one edge later.
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_q;
    logic cap_en_n;
    logic [SAMPLE_W-1:0] i_pin;
    logic [SAMPLE_W-1:0] q_pin;
    logic [1:0] phase_sel;
    logic load_pin;
    logic ser_bit;
    logic ser_sync;

    // Software-visible state and the oscillator.
    logic [31:0] hold_q;
    logic [1:0] config_q;
    logic [NCO_W-1:0] carrier_q;
    logic [NCO_W-1:0] offset_q;
    logic [NCO_W-1:0] shift_q;
    logic [CNT_W-1:0] bit_cnt_q;
    logic shifting_q;
    logic [NCO_W-1:0] phase_q;
    logic [NCO_W-1:0] phase_rot;

    // Formatted samples and the capture stage feeding the mixer.
    logic signed [SAMPLE_W-1:0] i_fmt;
    logic signed [SAMPLE_W-1:0] q_fmt;
    logic signed [SAMPLE_W-1:0] i_cap_q;
    logic signed [SAMPLE_W-1:0] q_cap_q;
    logic signed [LO_W-1:0] lo_cos_q;
    logic signed [LO_W-1:0] lo_sin_q;
    logic cap_valid_q;

    // Register bus decode.
    logic access;
    logic wr_fire;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [31:0] hold_d;

    assign pin_raw = {sample_capture_enable_n, inphase_sample_in,
                      quad_sample_in, carrier_phase_select,
                      carrier_freq_load, carrier_offset_serial_in,
                      carrier_offset_sync};
    assign {cap_en_n, i_pin, q_pin, phase_sel, load_pin, ser_bit,
            ser_sync} = pin_q;

    // The converter and the tracking loop are clocked by clk itself, so
    // the pins need no synchroniser: one register takes them all on the
    // same edge and keeps sync, serial bit and samples aligned. A filter
    // waiting for two stages to agree would swallow the one-clock sync
    // pulse and every lone serial bit.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_q <= PIN_RST;
        end else begin
            pin_q <= pin_raw;
        end
    end

    // APB decode; one wait state so that read data comes from a flop.
    assign access = psel && penable;
    assign wr_fire = access && pready && pwrite;
    always_comb begin
        addr_ok = 1'b1;
        rd_mux = '0;
        unique case (paddr)
            TFE_OFS_HOLD: rd_mux = hold_q;
            TFE_OFS_CONFIG: rd_mux[1:0] = config_q;
            TFE_OFS_CARRIER: rd_mux = 32'(carrier_q);
            TFE_OFS_OFFSET: rd_mux = 32'(offset_q);
            TFE_OFS_PHASE: rd_mux = 32'(phase_q);
            TFE_OFS_STATUS: begin
                rd_mux[TFE_STS_SHIFTING] = shifting_q;
                rd_mux[TFE_STS_CAPTURE] = ~cap_en_n;
            end
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= access && !pready;
            pslverr <= access && !pready && !addr_ok;
            if (access && !pready) begin
                prdata <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Byte-lane merge for the holding register.
    always_comb begin
        hold_d = hold_q;
        for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
                hold_d[8*b +: 8] = pwdata[8*b +: 8];
            end
        end
    end

    // Holding word; the controller keeps the load pin low meanwhile.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= TFE_HOLD_RST;
        end else if (wr_fire && paddr == TFE_OFS_HOLD) begin
            hold_q <= hold_d;
        end
    end

    // Format and real/complex selection; only the low byte matters.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_q <= TFE_CONFIG_RST;
        end else if (wr_fire && paddr == TFE_OFS_CONFIG && pstrb[0]) begin
            config_q <= pwdata[1:0];
        end
    end

    // Carrier word follows the holding word whenever the pin is high.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            carrier_q <= '0;
        end else if (load_pin) begin
            carrier_q <= NCO_W'(hold_q);
        end
    end

    // Serial offset: sync arms, then one bit a clock MSB first. A sync
    // inside a word restarts it, so a lost bit costs one word only.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shifting_q <= 1'b0;
            bit_cnt_q <= '0;
            shift_q <= '0;
            offset_q <= '0;
        end else if (ser_sync) begin
            shifting_q <= 1'b1;
            bit_cnt_q <= '0;
        end else if (shifting_q) begin
            shift_q <= {shift_q[NCO_W-2:0], ser_bit};
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (bit_cnt_q == LAST_BIT) begin
                shifting_q <= 1'b0;
                offset_q <= {shift_q[NCO_W-2:0], ser_bit};
            end
        end
    end

    // Accumulator step is the sample rate / 2^32, 0.0121 Hz at 52 MHz.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= '0;
        end else if (!cap_en_n) begin
            phase_q <= phase_q + carrier_q + offset_q;
        end
    end

    // Quarter-turn rotation: code n adds n times 90 degrees.
    assign phase_rot = phase_q
        + (NCO_W'(phase_sel) << QTR_SHIFT);

    // Quarter-wave sine table, sampled at half steps for symmetry.
    function automatic logic [LO_W-2:0] tfe_qsin(
        input logic [TFE_LUT_IDX_W-1:0] idx
    );
        unique case (idx)
            4'h0: tfe_qsin = 8'h0D;
            4'h1: tfe_qsin = 8'h25;
            4'h2: tfe_qsin = 8'h3E;
            4'h3: tfe_qsin = 8'h56;
            4'h4: tfe_qsin = 8'h6D;
            4'h5: tfe_qsin = 8'h83;
            4'h6: tfe_qsin = 8'h98;
            4'h7: tfe_qsin = 8'hAB;
            4'h8: tfe_qsin = 8'hBD;
            4'h9: tfe_qsin = 8'hCD;
            4'hA: tfe_qsin = 8'hDB;
            4'hB: tfe_qsin = 8'hE7;
            4'hC: tfe_qsin = 8'hF0;
            4'hD: tfe_qsin = 8'hF7;
            4'hE: tfe_qsin = 8'hFC;
            4'hF: tfe_qsin = 8'hFF;
        endcase
    endfunction : tfe_qsin

    // Full sine from quadrant folding; cosine is sine a quarter ahead.
    function automatic logic signed [LO_W-1:0] tfe_sin(
        input logic [TFE_LUT_IDX_W+1:0] ph
    );
        logic [LO_W-2:0] mag;
        mag = ph[TFE_LUT_IDX_W] ? tfe_qsin(~ph[TFE_LUT_IDX_W-1:0])
                                : tfe_qsin(ph[TFE_LUT_IDX_W-1:0]);
        tfe_sin = ph[TFE_LUT_IDX_W+1] ? -$signed({1'b0, mag})
                                      : $signed({1'b0, mag});
    endfunction : tfe_sin

    // Offset binary differs from two's complement only in the MSB.
    assign i_fmt = config_q[TFE_CFG_OFFBIN] == TFE_FMT_OFFBIN
        ? {~i_pin[SAMPLE_W-1], i_pin[SAMPLE_W-2:0]} : i_pin;
    assign q_fmt = !config_q[TFE_CFG_COMPLEX] ? '0
        : config_q[TFE_CFG_OFFBIN] == TFE_FMT_OFFBIN
        ? {~q_pin[SAMPLE_W-1], q_pin[SAMPLE_W-2:0]} : q_pin;

    // Capture stage: samples and oscillator taken on the same edge.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            i_cap_q <= '0;
            q_cap_q <= '0;
            lo_cos_q <= '0;
            lo_sin_q <= '0;
            cap_valid_q <= 1'b0;
        end else begin
            cap_valid_q <= !cap_en_n;
            if (!cap_en_n) begin
                i_cap_q <= i_fmt;
                q_cap_q <= q_fmt;
                lo_sin_q <= tfe_sin(phase_rot[NCO_W-1 -: LUT_PH_W]);
                lo_cos_q <= tfe_sin(phase_rot[NCO_W-1 -: LUT_PH_W]
                    + LUT_QTR);
            end
        end
    end

    // Mixer (I + jQ)(cos - j sin); one multiply stage keeps it well
    // inside 5 ns, far above the 52 MSPS the path must sustain.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mix_i_out <= '0;
            mix_q_out <= '0;
            mix_valid <= 1'b0;
        end else begin
            mix_valid <= cap_valid_q;
            if (cap_valid_q) begin
                mix_i_out <= MIX_W'(i_cap_q * lo_cos_q)
                    + MIX_W'(q_cap_q * lo_sin_q);
                mix_q_out <= MIX_W'(q_cap_q * lo_cos_q)
                    - MIX_W'(i_cap_q * lo_sin_q);
            end
        end
    end
endmodule : tfe_top
`default_nettype wire

// [sim/tfe_sva.sv]
// Checker for the tuner front end: APB timing and sample capture.
// Assumes it is bound to tfe_top and sees only its ports.
`default_nettype none
module tfe_chk (
    input wire logic clk, // Clock.
    input wire logic sys_rst, // Reset, high.
    input wire logic sample_capture_enable_n, // Capture enable, low.
    input wire logic [7:0] paddr, // APB address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic mix_valid // Mixed pair valid.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // An access phase still waiting for its answer.
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // Enable released and kept high for seven further clocks.
    sequence s_idle;
        $rose(sample_capture_enable_n) ##1 sample_capture_enable_n[*7];
    endsequence
    a_ready_one_wait: assert property (s_wait |=> pready)
        else $error("pready missing one cycle into access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");
    a_ready_needs_access: assert property (!(psel && penable) |=> !pready)
        else $error("pready without an access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside the answer cycle");
    a_unmapped_err: assert property (s_wait ##0 paddr >= 8'h18 |=> pslverr)
        else $error("unmapped access answered without error");
    a_mapped_no_err: assert property (s_wait
        ##0 (paddr <= 8'h14 && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped access answered with error");
    a_rdata_holds: assert property (!(psel && penable) |=> $stable(prdata))
        else $error("prdata moved between accesses");
    a_capture_starts: assert property (
        $fell(sample_capture_enable_n) |-> ##[1:8] mix_valid)
        else $error("no mixed output after capture enabled");
    a_capture_stops: assert property (s_idle |-> !mix_valid)
        else $error("mixed output while capture disabled");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !pready && !mix_valid)
        else $error("outputs active right after reset");
endmodule : tfe_chk
`default_nettype wire

// [sim/tfe_src.sv]
// Model of the A/D converter and carrier tracking loop on the pins.
// Assumes the bench calls its tasks; pins move just after posedge.
`default_nettype none
module tfe_src (
    input wire logic clk, // Sample clock.
    output logic enable_n, // Capture enable, low.
    output logic [9:0] i_smp, // In-phase sample.
    output logic [9:0] q_smp, // Quadrature sample.
    output logic sync, // Offset word sync.
    output logic ser // Serial offset bit.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        enable_n = 1'h1;
        i_smp = 10'h155;
        q_smp = 10'h2AA;
        sync = 1'h0;
        ser = 1'h0;
    end
    // Hold one pair for n enabled clocks; after it the buses carry junk.
    task automatic stream(input int n, input logic [9:0] i,
        input logic [9:0] q);
        repeat (n) begin
            @(posedge clk);
            enable_n <= 1'h0;
            i_smp <= i;
            q_smp <= q;
        end
        @(posedge clk);
        enable_n <= 1'h1;
        i_smp <= ~i;
        q_smp <= ~q;
    endtask : stream
    // Sync, then nb bits of w MSB first; a short word is simply cut off.
    task automatic word(input logic [31:0] w, input int nb);
        @(posedge clk);
        sync <= 1'h1;
        for (int k = 31; k > 31 - nb; k--) begin
            @(posedge clk);
            sync <= 1'h0;
            ser <= w[k];
        end
        @(posedge clk);
        ser <= ~ser;
    endtask : word
endmodule : tfe_src
`default_nettype wire

// [sim/tuner_front_end_carrier_load_tb_top.sv]
// Self-checking bench for the tuner front end and its pin partner.
// Assumes tfe_pkg, tfe_top, tfe_src and tfe_chk are compiled first.
`default_nettype none
module tuner_front_end_carrier_load_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tfe_pkg::*;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, mix_valid;
    logic en_n, sync, ser, load, er;
    logic [1:0] phase;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, p0;
    logic [9:0] i_smp, q_smp;
    logic signed [TFE_MIX_W-1:0] mi, mq, gi, gq, i0, q0;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    tfe_top dut_u (.clk, .sys_rst, .sample_capture_enable_n(en_n),
        .inphase_sample_in(i_smp), .quad_sample_in(q_smp),
        .carrier_phase_select(phase), .carrier_freq_load(load),
        .carrier_offset_serial_in(ser), .carrier_offset_sync(sync), .paddr,
        .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF), .prdata, .pready,
        .pslverr, .mix_i_out(mi), .mix_q_out(mq), .mix_valid);
    tfe_src src_u (.clk, .enable_n(en_n), .i_smp, .q_smp, .sync, .ser);
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // The whole run needs about four hundred clocks; this only cuts a hang.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic t_load();
        apb(1'h0, TFE_OFS_HOLD, 32'h0);
        chk(rd, TFE_HOLD_RST);
        apb(1'h0, 8'h18, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'h1, TFE_OFS_HOLD, 32'h0123_4567);
        apb(1'h1, TFE_OFS_CONFIG, 32'h3);
        apb(1'h0, TFE_OFS_CONFIG, 32'h0);
        chk(rd, 32'h3);
        @(posedge clk);
        load <= 1'h1;
        repeat (3) @(posedge clk);
        load <= 1'h0;
        apb(1'h1, TFE_OFS_HOLD, 32'hA5A5_0F0F);
        apb(1'h1, TFE_OFS_CARRIER, 32'hFFFF_FFFF);
        apb(1'h0, TFE_OFS_CARRIER, 32'h0);
        chk(rd, 32'h0123_4567);
        $display("t_load done");
    endtask : t_load
    task automatic t_serial();
        src_u.word(32'hF0E1_D2C3, 32);
        apb(1'h0, TFE_OFS_OFFSET, 32'h0);
        chk(rd, 32'hF0E1_D2C3);
        // A cut word leaves the shifter busy until 32 bits are counted; a sync before that restarts the word.
        fork
            src_u.word(32'h0000_0000, 12);
            begin
                repeat (4) @(posedge clk);
                apb(1'h0, TFE_OFS_STATUS, 32'h0);
                chk(rd, 32'h1 << TFE_STS_SHIFTING);
            end
        join
        src_u.word(32'h1234_5678, 32);
        apb(1'h0, TFE_OFS_OFFSET, 32'h0);
        chk(rd, 32'h1234_5678);
        apb(1'h0, TFE_OFS_PHASE, 32'h0);
        p0 = rd;
        src_u.stream(16, 10'h000, 10'h000);
        repeat (10) @(posedge clk);
        apb(1'h0, TFE_OFS_PHASE, 32'h0);
        chk(rd - p0, 32'(16 * (32'h0123_4567 + 32'h1234_5678)));
        $display("t_serial done");
    endtask : t_serial
    // Streams one pair and takes the mixer outputs once they settle.
    task automatic run(input logic [1:0] ph, input logic [1:0] cfg,
        input logic [9:0] i, input logic [9:0] q);
        @(posedge clk);
        phase <= ph;
        apb(1'h1, TFE_OFS_CONFIG, {30'h0, cfg});
        fork
            src_u.stream(20, i, q);
            begin
                repeat (16) @(posedge clk);
                gi = mi;
                gq = mq;
                chk(32'(mix_valid), 32'h1);
            end
        join
    endtask : run
    // With zero frequency the LO stands still, so rotations compare.
    task automatic t_mix();
        apb(1'h1, TFE_OFS_HOLD, 32'h0);
        @(posedge clk);
        load <= 1'h1;
        repeat (3) @(posedge clk);
        load <= 1'h0;
        src_u.word(32'h0, 32);
        run(2'h0, 2'h0, 10'h064, 10'h064);
        i0 = gi;
        q0 = gq;
        chk(32'(gi != 0 || gq != 0), 32'h1);
        run(2'h1, 2'h0, 10'h064, 10'h000);
        chk(gi, q0);
        chk(gq, -i0);
        run(2'h2, 2'h0, 10'h064, 10'h000);
        chk(gi, -i0);
        run(2'h3, 2'h0, 10'h064, 10'h000);
        chk(gq, i0);
        run(2'h0, 2'h1, 10'h264, 10'h200);
        chk(gi, i0);
        run(2'h0, 2'h0, 10'h39C, 10'h000);
        chk(gq, -q0);
        run(2'h0, 2'h2, 10'h000, 10'h064);
        chk(gi, -q0);
        chk(gq, i0);
        $display("t_mix done");
    endtask : t_mix
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        {sys_rst, psel, penable, pwrite, load} = 5'h10;
        paddr = 8'h00;
        pwdata = 32'h0;
        phase = 2'h0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (6) @(posedge clk);
        t_load();
        t_serial();
        t_mix();
        conclude();
    end
endmodule : tuner_front_end_carrier_load_tb_top
bind tfe_top tfe_chk chk_u (.clk, .sys_rst, .sample_capture_enable_n,
    .paddr, .psel, .penable, .pready, .pslverr, .prdata, .mix_valid);
`default_nettype wire
